// >>> rtc_year_weekday_alarm_regs.sv
// Year, weekday and alarm second/minute/hour registers with alarm interrupt.
// Assumes a single-cycle strobe register port and the running time on the same clock.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
module rtc_year_weekday_alarm_regs
   import rtc_regs_pkg::*;
(
   input  wire logic              I_CLK,
   input  wire logic              I_NRST,
   input  wire logic [ADDR_W-1:0] I_ADDR,
   input  wire logic [DATA_W-1:0] I_WDATA,
   input  wire logic              I_WR,
   input  wire logic              I_RD,
   input  wire logic [6:0]        I_NOW_SEC,
   input  wire logic [6:0]        I_NOW_MIN,
   input  wire logic [7:0]        I_NOW_HOUR,
   output logic [DATA_W-1:0]      O_RDATA,
   output logic [7:0]             O_YEAR,
   output logic [2:0]             O_WEEKDAY,
   output logic                   O_IRQ
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers.

   function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
      zext8 = {{(DATA_W-8){1'b0}}, v};
   endfunction

   function automatic logic bcd_ok(input logic [3:0] d);
      bcd_ok = (d <= BCD_MAX);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.

   bus_req_t req;
   logic     unlocked;
   logic     alarm_hit;

   assign req.wr    = I_WR;
   assign req.rd    = I_RD;
   assign req.addr  = I_ADDR;
   assign req.wdata = I_WDATA;

   wire wr_open   = I_WR && unlocked;
   wire wr_year   = wr_open && I_ADDR == OFF_YEAR;
   wire wr_wday   = wr_open && I_ADDR == OFF_WEEKDAY;
   wire wr_asec   = wr_open && I_ADDR == OFF_ALM_SEC;
   wire wr_amin   = wr_open && I_ADDR == OFF_ALM_MIN;
   wire wr_ahour  = wr_open && I_ADDR == OFF_ALM_HOUR;
   wire wr_ien    = I_WR && I_ADDR == OFF_IRQ_ENABLE;
   wire wr_iclr   = I_WR && I_ADDR == OFF_IRQ_CLEAR;

   rtc_unlock u_unlock (
      .i_clk      (I_CLK),
      .i_nrst     (I_NRST),
      .i_req      (req),
      .o_unlocked (unlocked)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Storage.

   logic [7:0] year;
   logic [2:0] weekday;
   logic [6:0] alm_sec;
   logic [6:0] alm_min;
   logic [7:0] alm_hour;
   logic       irq_status;
   logic       irq_enable;

   // Out-of-range values are stored as written, except that alarm hour bit 6 is cleared; software owns validity.
   always_ff @(posedge I_CLK) begin
      if (!I_NRST) year <= RST_YEAR;
      else if (wr_year) year <= I_WDATA[7:0];
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) weekday <= RST_WEEKDAY;
      else if (wr_wday) weekday <= I_WDATA[2:0];
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) alm_sec <= RST_ALM_SEC;
      else if (wr_asec) alm_sec <= I_WDATA[6:0] & MASK_SEC;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) alm_min <= RST_ALM_MIN;
      else if (wr_amin) alm_min <= I_WDATA[6:0] & MASK_SEC;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) alm_hour <= RST_ALM_HOUR;
      else if (wr_ahour) alm_hour <= I_WDATA[7:0] & MASK_HOUR;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm compare and interrupt.

   time_t now_t;
   time_t alarm_t;
   assign now_t   = '{seconds: I_NOW_SEC, minutes: I_NOW_MIN, hours: I_NOW_HOUR};
   assign alarm_t = '{seconds: alm_sec, minutes: alm_min, hours: alm_hour};

   rtc_alarm_match u_match (
      .i_clk   (I_CLK),
      .i_nrst  (I_NRST),
      .i_now   (now_t),
      .i_alarm (alarm_t),
      .o_hit   (alarm_hit)
   );

   // A new event wins over a clear in the same cycle.
   wire next_status = alarm_hit | (irq_status & ~(wr_iclr & I_WDATA[0]));

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) begin
         irq_status <= 1'b0;
         irq_enable <= 1'b0;
      end else begin
         irq_status <= next_status;
         if (wr_ien) irq_enable <= I_WDATA[0];
      end
   end

   assign O_IRQ = irq_status & irq_enable;

   ////////////////////////////////////////////////////////////////////////////////
   // Read path.

   logic [DATA_W-1:0] next_rdata;
   always_comb begin
      case (I_ADDR)
         OFF_YEAR:       next_rdata = zext8(year);
         OFF_WEEKDAY:    next_rdata = zext8({5'h00, weekday});
         OFF_ALM_SEC:    next_rdata = zext8({1'b0, alm_sec});
         OFF_ALM_MIN:    next_rdata = zext8({1'b0, alm_min});
         OFF_ALM_HOUR:   next_rdata = zext8(alm_hour);
         OFF_IRQ_STATUS: next_rdata = zext8({7'h00, irq_status});
         OFF_IRQ_ENABLE: next_rdata = zext8({7'h00, irq_enable});
         OFF_LOCK_STATE: next_rdata = zext8({7'h00, unlocked});
         default:        next_rdata = '0;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_NRST) O_RDATA <= '0;
      else if (I_RD) O_RDATA <= next_rdata;
      else O_RDATA <= '0;
   end

   assign O_YEAR    = year;
   assign O_WEEKDAY = weekday;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   locked_wr_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_WR && !unlocked && I_ADDR == OFF_YEAR |=> $stable(year))
      else $error("Year changed while locked.");

   year_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_year |=> year == $past(I_WDATA[7:0]))
      else $error("Year did not take the written value.");

   year_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_YEAR |=> O_RDATA[31:8] == 24'h00_0000)
      else $error("Year reserved bits nonzero.");

   wday_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_WEEKDAY |=> O_RDATA[31:3] == 29'h0000_0000)
      else $error("Weekday upper bits nonzero.");

   sec_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_SEC |=> O_RDATA[31:7] == 25'h000_0000)
      else $error("Alarm seconds reserved bits nonzero.");

   min_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_amin |=> alm_min == $past(I_WDATA[6:0]))
      else $error("Alarm minutes not stored.");

   hour_bit6_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_HOUR |=> O_RDATA[6] == 1'b0)
      else $error("Alarm hour bit six nonzero.");

   pm_flag_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_ahour |=> alm_hour[MERIDIEM_POS] == $past(I_WDATA[7]))
      else $error("PM flag not stored.");

   reset_zero_a: assert property (@(posedge I_CLK)
      !I_NRST |=> year == 8'h00 && weekday == 3'h0 && alm_hour == 8'h00)
      else $error("Registers not zero after reset.");

   alarm_irq_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      alarm_hit && irq_enable && !wr_ien |=> O_IRQ)
      else $error("Alarm match did not raise interrupt.");

   alarm_own_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      !wr_asec && !wr_amin && !wr_ahour |=> $stable(alarm_t))
      else $error("Alarm time changed without a write.");

   wday_locked_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_WR && !unlocked && I_ADDR == OFF_WEEKDAY |=> $stable(weekday))
      else $error("Weekday changed while locked.");

   sec_locked_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_WR && !unlocked && I_ADDR == OFF_ALM_SEC |=> $stable(alm_sec))
      else $error("Alarm seconds changed while locked.");

   min_locked_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_WR && !unlocked && I_ADDR == OFF_ALM_MIN |=> $stable(alm_min))
      else $error("Alarm minutes changed while locked.");

   hour_locked_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_WR && !unlocked && I_ADDR == OFF_ALM_HOUR |=> $stable(alm_hour))
      else $error("Alarm hours changed while locked.");

   lock_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_LOCK_STATE |=> O_RDATA == {31'h0000_0000, $past(unlocked)})
      else $error("Lock state read wrong.");

   year_hold_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      !wr_year |=> $stable(year))
      else $error("Year changed without a write.");

   year_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_YEAR |=> O_RDATA[7:0] == $past(year))
      else $error("Year read wrong.");

   hour_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_HOUR |=> O_RDATA[31:8] == 24'h00_0000)
      else $error("Alarm hour reserved bits nonzero.");

   wday_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_wday |=> weekday == $past(I_WDATA[2:0]))
      else $error("Weekday did not take the written value.");

   wday_hold_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      !wr_wday |=> $stable(weekday))
      else $error("Weekday changed without a write.");

   wday_value_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_WEEKDAY |=> O_RDATA[2:0] == $past(weekday))
      else $error("Weekday read wrong.");

   sec_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_asec |=> alm_sec == $past(I_WDATA[6:0]))
      else $error("Alarm seconds not stored.");

   sec_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_SEC |=> O_RDATA[6:0] == $past(alm_sec))
      else $error("Alarm seconds read wrong.");

   min_rsvd_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_MIN |=> O_RDATA[31:7] == 25'h000_0000)
      else $error("Alarm minutes reserved bits nonzero.");

   min_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_MIN |=> O_RDATA[6:0] == $past(alm_min))
      else $error("Alarm minutes read wrong.");

   hour_write_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_ahour |=> alm_hour[5:0] == $past(I_WDATA[5:0]) && !alm_hour[6])
      else $error("Alarm hours not stored.");

   hour_read_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      I_RD && I_ADDR == OFF_ALM_HOUR |=> O_RDATA[7:0] == $past(alm_hour))
      else $error("Alarm hours read wrong.");

   alarm_reset_a: assert property (@(posedge I_CLK)
      !I_NRST |=> alm_sec == 7'h00 && alm_min == 7'h00 && !O_IRQ && O_RDATA == '0)
      else $error("Alarm or outputs not zero after reset.");

   status_set_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      alarm_hit |=> irq_status)
      else $error("Alarm event did not set status.");

   status_hold_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      irq_status && !(wr_iclr && I_WDATA[0]) |=> irq_status)
      else $error("Status dropped without a clear.");

   status_clear_a: assert property (@(posedge I_CLK) disable iff (!I_NRST)
      wr_iclr && I_WDATA[0] && !alarm_hit |=> !irq_status)
      else $error("Status not cleared.");

   // Covers for the main scenarios.
   cov_unlock: cover property (@(posedge I_CLK) $rose(unlocked));
   cov_year_wr: cover property (@(posedge I_CLK) wr_year);
   cov_alarm: cover property (@(posedge I_CLK) alarm_hit && irq_enable);
   cov_clr_race: cover property (@(posedge I_CLK) alarm_hit && wr_iclr);
   cov_bcd_year: cover property (@(posedge I_CLK)
      wr_year && bcd_ok(I_WDATA[7:4]) && bcd_ok(I_WDATA[3:0]));

endmodule // rtc_year_weekday_alarm_regs

// >>> rtc_regs_pkg.sv
// Package for the year, weekday and alarm register block.
// Assumes a plain register port with 32-bit data and word byte addresses.
package rtc_regs_pkg;

   localparam int          ADDR_W           = 8;
   localparam int          DATA_W           = 32;
   localparam logic [7:0]  OFF_YEAR         = 8'h00;
   localparam logic [7:0]  OFF_WEEKDAY      = 8'h04;
   localparam logic [7:0]  OFF_ALM_SEC      = 8'h08;
   localparam logic [7:0]  OFF_ALM_MIN      = 8'h0C;
   localparam logic [7:0]  OFF_ALM_HOUR     = 8'h10;
   localparam logic [7:0]  OFF_UNLOCK0      = 8'h14;
   localparam logic [7:0]  OFF_UNLOCK1      = 8'h18;
   localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h1C;
   localparam logic [7:0]  OFF_IRQ_ENABLE   = 8'h20;
   localparam logic [7:0]  OFF_IRQ_CLEAR    = 8'h24;
   localparam logic [7:0]  OFF_LOCK_STATE   = 8'h28;
   // Unlock key values are arbitrary.
   localparam logic [31:0] UNLOCK_KEY0      = 32'h1234_5678;
   localparam logic [31:0] UNLOCK_KEY1      = 32'h9ABC_DEF0;
   localparam int          TENS_POS         = 4;
   localparam int          MERIDIEM_POS     = 7;
   localparam logic [7:0]  RST_YEAR         = 8'h00;
   localparam logic [2:0]  RST_WEEKDAY      = 3'h0;
   localparam logic [6:0]  RST_ALM_SEC      = 7'h00;
   localparam logic [6:0]  RST_ALM_MIN      = 7'h00;
   localparam logic [7:0]  RST_ALM_HOUR     = 8'h00;
   localparam logic [6:0]  MASK_SEC         = 7'h7F;
   localparam logic [7:0]  MASK_HOUR        = 8'hBF;
   localparam logic [2:0]  WEEKDAY_MAX      = 3'h6;
   localparam logic [3:0]  BCD_MAX          = 4'h9;

   typedef struct packed {
      logic [6:0] seconds;
      logic [6:0] minutes;
      logic [7:0] hours;
   } time_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_t;

endpackage

// >>> rtc_unlock.sv
// Write-protect unlock sequencer: two keys in order open the registers.
// Assumes bus strobes are single cycle on the same clock.
`timescale 1ns/100ps
module rtc_unlock
   import rtc_regs_pkg::*;
(
   input  wire logic     i_clk,
   input  wire logic     i_nrst,
   input  wire bus_req_t i_req,
   output logic          o_unlocked
);

   typedef enum logic [1:0] {
      LK_LOCKED = 2'b00,
      LK_HALF   = 2'b01,
      LK_OPEN   = 2'b10
   } lock_state_t;

   lock_state_t state;
   lock_state_t next_state;
   wire         key0_hit = i_req.wr && i_req.addr == OFF_UNLOCK0 && i_req.wdata == UNLOCK_KEY0;
   wire         key1_hit = i_req.wr && i_req.addr == OFF_UNLOCK1 && i_req.wdata == UNLOCK_KEY1;
   wire         key_wr   = i_req.wr && (i_req.addr == OFF_UNLOCK0 || i_req.addr == OFF_UNLOCK1);

   // A wrong key write anywhere in the sequence relocks the block.
   always_comb begin
      next_state = state;
      case (state)
         LK_LOCKED: if (key0_hit) next_state = LK_HALF;
         LK_HALF: begin
            if (key1_hit) next_state = LK_OPEN;
            else if (key_wr) next_state = LK_LOCKED;
         end
         LK_OPEN: if (key_wr && !key0_hit && !key1_hit) next_state = LK_LOCKED;
         default: next_state = LK_LOCKED;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) state <= LK_LOCKED;
      else state <= next_state;
   end

   assign o_unlocked = (state == LK_OPEN);

   lock_after_rst_a: assert property (@(posedge i_clk) !i_nrst |=> !o_unlocked)
      else $error("Unlocked right after reset.");

endmodule // rtc_unlock

// >>> rtc_alarm_match.sv
// Compares running time against alarm time and pulses on a new match.
// Assumes the running time arrives on the same clock.
`timescale 1ns/100ps
module rtc_alarm_match
   import rtc_regs_pkg::*;
(
   input  wire logic  i_clk,
   input  wire logic  i_nrst,
   input  wire time_t i_now,
   input  wire time_t i_alarm,
   output logic       o_hit
);

   logic matched;
   wire  equal = (i_now == i_alarm);

   always_ff @(posedge i_clk) begin
      if (!i_nrst) matched <= 1'b0;
      else matched <= equal;
   end

   // Only the first cycle of a match fires, so a held time raises one event.
   assign o_hit = equal && !matched;

   // A match that stands through reset fires once after release, so the
   // previous cycle only counts when it was out of reset.
   hit_needs_eq_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_hit |-> i_now == i_alarm && !($past(equal) && $past(i_nrst)))
      else $error("Alarm event without a fresh match.");

endmodule // rtc_alarm_match

// >>> test_rtc_year_weekday_alarm_regs.sv
// Self-checking testbench for the year, weekday and alarm register block.
// Assumes the design package and modules are compiled first.
`timescale 1ns/100ps
module test_rtc_year_weekday_alarm_regs
   import rtc_regs_pkg::*;
;
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic [DATA_W-1:0] wdata = 32'h0000_0000;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [6:0]        now_sec = 7'h41;
   logic [6:0]        now_min = 7'h00;
   logic [7:0]        now_hour = 8'h00;
   logic [DATA_W-1:0] rdata;
   logic [7:0]        year;
   logic [2:0]        weekday;
   logic              irq;
   logic [DATA_W-1:0] exp_q[$];
   logic              rd_seen = 1'b0;
   logic [DATA_W-1:0] exp_v;
   int                miscompares = 0;
   int                check_count = 0;
   int                seed = 32'ha932_0b76;
   logic [31:0]       rnd;

   rtc_year_weekday_alarm_regs uut (
      .I_CLK      (clk),
      .I_NRST     (nrst),
      .I_ADDR     (addr),
      .I_WDATA    (wdata),
      .I_WR       (wr),
      .I_RD       (rd),
      .I_NOW_SEC  (now_sec),
      .I_NOW_MIN  (now_min),
      .I_NOW_HOUR (now_hour),
      .O_RDATA    (rdata),
      .O_YEAR     (year),
      .O_WEEKDAY  (weekday),
      .O_IRQ      (irq)
   );

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Read data stand only in the cycle after the strobe, so the monitor looks there.
   always @(posedge clk) begin
      rd_seen <= rd;
   end

   always @(negedge clk) begin
      if (rd_seen) begin
         exp_v = exp_q.pop_front();
         `CHK(rdata, exp_v)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      wr    <= 1'b1;
      rd    <= 1'b0;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      rd   <= 1'b1;
      wr   <= 1'b0;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
   endtask

   // Drops the strobes, lets one edge pass, then compares the level outputs.
   task automatic chk_out(input logic e_irq, input logic [7:0] e_year);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
      `CHK(irq, e_irq)
      `CHK(year, e_year)
      @(posedge clk);
   endtask

   task automatic set_now(input logic [6:0] s, input logic [6:0] m, input logic [7:0] h);
      now_sec  <= s;
      now_min  <= m;
      now_hour <= h;
      wr       <= 1'b0;
      rd       <= 1'b0;
      @(posedge clk);
   endtask

   task automatic finish_test;
      $display("TB: %0d checks, %0d mismatches", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #20000;
      miscompares++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(OFF_YEAR, 32'h0000_0000);
      rd_reg(OFF_WEEKDAY, 32'h0000_0000);
      rd_reg(OFF_ALM_SEC, 32'h0000_0000);
      rd_reg(OFF_ALM_MIN, 32'h0000_0000);
      rd_reg(OFF_ALM_HOUR, 32'h0000_0000);
      wr_reg(OFF_YEAR, 32'h0000_0042);
      rd_reg(OFF_YEAR, 32'h0000_0000);
      chk_out(1'b0, 8'h00);
      $display("TB: reset and lock test done");
      wr_reg(OFF_UNLOCK0, UNLOCK_KEY0);
      wr_reg(OFF_UNLOCK1, UNLOCK_KEY1);
      rd_reg(OFF_LOCK_STATE, 32'h0000_0001);
      wr_reg(OFF_YEAR, 32'hFFFF_FF59);
      rd_reg(OFF_YEAR, 32'h0000_0059);
      for (int d = 0; d <= 6; d++) begin
         rnd = $random(seed);
         wr_reg(OFF_WEEKDAY, {rnd[31:3], d[2:0]});
         rd_reg(OFF_WEEKDAY, {29'h0000_0000, d[2:0]});
         `CHK(weekday, d[2:0])
      end
      wr_reg(OFF_ALM_SEC, 32'hFFFF_FFFF);
      rd_reg(OFF_ALM_SEC, 32'h0000_007F);
      wr_reg(OFF_ALM_MIN, 32'hFFFF_FFFF);
      rd_reg(OFF_ALM_MIN, 32'h0000_007F);
      wr_reg(OFF_ALM_HOUR, 32'hFFFF_FFFF);
      rd_reg(OFF_ALM_HOUR, 32'h0000_00BF);
      rd_reg(8'h3C, 32'h0000_0000);
      chk_out(1'b0, 8'h59);
      $display("TB: field test done");
      wr_reg(OFF_ALM_SEC, 32'h0000_0030);
      wr_reg(OFF_ALM_MIN, 32'h0000_0015);
      wr_reg(OFF_ALM_HOUR, 32'h0000_0092);
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0001);
      rd_reg(OFF_IRQ_ENABLE, 32'h0000_0001);
      rnd = $random(seed);
      set_now(7'h30, 7'h15, 8'h12);
      chk_out(1'b0, 8'h59);
      set_now(7'h30, {1'b1, rnd[5:0]}, 8'h92);
      chk_out(1'b0, 8'h59);
      set_now(7'h30, 7'h15, 8'h92);
      chk_out(1'b1, 8'h59);
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0001);
      rd_reg(OFF_IRQ_STATUS, 32'h0000_0000);
      chk_out(1'b0, 8'h59);
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0000);
      set_now(7'h31, 7'h15, 8'h92);
      set_now(7'h30, 7'h15, 8'h92);
      rd_reg(OFF_IRQ_STATUS, 32'h0000_0001);
      chk_out(1'b0, 8'h59);
      wr_reg(OFF_IRQ_ENABLE, 32'h0000_0001);
      chk_out(1'b1, 8'h59);
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0001);
      set_now(7'h31, 7'h15, 8'h92);
      now_sec <= 7'h30;
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0001);
      rd_reg(OFF_IRQ_STATUS, 32'h0000_0001);
      wr_reg(OFF_IRQ_CLEAR, 32'h0000_0001);
      rd_reg(OFF_IRQ_CLEAR, 32'h0000_0000);
      $display("TB: alarm test done");
      wr_reg(OFF_UNLOCK0, 32'h0000_0000);
      wr_reg(OFF_YEAR, 32'h0000_0011);
      wr_reg(OFF_ALM_HOUR, 32'h0000_0001);
      rd_reg(OFF_YEAR, 32'h0000_0059);
      rd_reg(OFF_ALM_HOUR, 32'h0000_0092);
      chk_out(1'b0, 8'h59);
      $display("TB: relock test done");
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd_reg(OFF_LOCK_STATE, 32'h0000_0000);
      wr_reg(OFF_YEAR, 32'h0000_0033);
      rd_reg(OFF_YEAR, 32'h0000_0000);
      rd_reg(OFF_ALM_HOUR, 32'h0000_0000);
      chk_out(1'b0, 8'h00);
      $display("TB: mid-run reset test done");
      finish_test();
   end
endmodule // test_rtc_year_weekday_alarm_regs
